// ==== rtl/sd_supervisor_diag.sv ====
// Purpose: Regulator supervision, temperature warning and upset check
// Assumes: Comparators and temperature code arrive as pins
// Notes:   Control bits are ports; only reads travel over the link
`timescale 1ns/1ps
module sd_supervisor_diag
    import sd_pkg::*;
#(
    parameter int AUTORETRY_CYCLES = AUTORETRY_OFF_CYC,
    parameter int SOFTSTART_CYCLES = SOFTSTART_CYC,
    parameter int CONV_CYCLES = CONV_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic csN,
    input wire logic mosi,
    output logic miso,
    input wire logic cfgWrite,
    input wire sd_ctrl_t cfgData,
    input wire logic convGoWrite,
    input wire logic [CTRL_W-1:0] upsetFlip,
    input wire sd_pins_t analogPins,
    input wire logic [5:0] dieTempCode,
    output sd_ctrl_t ctrlOut,
    output logic regClkTick,
    output logic hsSwitchOff,
    output logic lsSwitchOff,
    output logic regEnable,
    output logic regulatorGoodFlag,
    output logic regulatorFaultFlag,
    output logic powerGoodOut,
    output logic tempWarnStatus,
    output logic tempWarnIrqFlag,
    output logic irq,
    output logic convGo,
    output logic convDone,
    output logic [5:0] tempResult,
    output logic thermalShutdown,
    output logic regUpsetFlag,
    output logic setupLostFlag,
    output logic lineDriverEnable,
    output logic ldoEnable
);
    // ---- Synchronised inputs ----
    sd_pins_t pinS; // Comparators in mclk domain
    logic [5:0] tempS; // Temperature code in mclk domain
    logic [CTRL_W-1:0] flipS; // Upset strobe levels
    logic [CTRL_W-1:0] flipPrev_q; // Previous upset levels
    logic intReadS; // Interrupt read level from link
    logic intReadPrev_q; // Previous read level
    logic intReadDone; // Link-domain read marker

    sd_sync2 #(.W(PINS_W)) uPinSync (
        .clk(mclk),
        .din(analogPins),
        .dout(pinS)
    );
    sd_sync2 #(.W(6)) uTempSync (
        .clk(mclk),
        .din(dieTempCode),
        .dout(tempS)
    );
    sd_sync2 #(.W(CTRL_W)) uFlipSync (
        .clk(mclk),
        .din(upsetFlip),
        .dout(flipS)
    );
    sd_sync2 #(.W(1)) uReadSync (
        .clk(mclk),
        .din(intReadDone),
        .dout(intReadS)
    );

    // ---- Serial link on the master's clock ----
    sd_stat_t statOut; // Status word toward the link
    assign statOut = '{setupLostFlag: setupLostFlag,
                       tempWarnIrqFlag: tempWarnIrqFlag,
                       tempWarnStatus: tempWarnStatus,
                       regUpsetFlag: regUpsetFlag,
                       regulatorFaultFlag: regulatorFaultFlag,
                       regulatorGoodFlag: regulatorGoodFlag,
                       convDone: convDone,
                       tempResult: tempResult};

    sd_spi_link uLink (
        .sclk(sclk),
        .csN(csN),
        .mosi(mosi),
        .miso(miso),
        .statIn(statOut),
        .intReadDone(intReadDone)
    );

    // Rising edge of the read level is one read event
    wire intReadEv = intReadS && !intReadPrev_q;
    wire [CTRL_W-1:0] flipEv = flipS & ~flipPrev_q;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            intReadPrev_q <= 1'b0;
            flipPrev_q <= '0;
        end else begin
            intReadPrev_q <= intReadS;
            flipPrev_q <= flipS;
        end
    end

    // ---- Control register with upset check ----
    sd_ctrl_t ctrl_q; // Live control image
    sd_ctrl_t golden_q; // Image before any upset
    logic upset_q; // Upset flag
    logic setupLost_q; // Not-ready flag
    wire mismatch = (ctrl_q != golden_q);
    wire sd_ctrl_t ctrl_d = cfgWrite ? cfgData : sd_ctrl_t'(ctrl_q ^ flipEv);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_q <= CTRL_RESET;
            golden_q <= CTRL_RESET;
        end else begin
            ctrl_q <= ctrl_d;
            // Reference follows writes only while intact
            if (cfgWrite && !upset_q && !mismatch) begin
                golden_q <= cfgData;
            end
        end
    end

    // Upset and not-ready flags; set wins over read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            upset_q <= 1'b0;
            setupLost_q <= 1'b1;
        end else begin
            upset_q <= mismatch;
            if (mismatch) begin
                setupLost_q <= 1'b1;
            end else if (intReadEv && !upset_q) begin
                setupLost_q <= 1'b0;
            end
        end
    end

    assign ctrlOut = ctrl_q;
    assign regUpsetFlag = upset_q;
    assign setupLostFlag = setupLost_q;

    // ---- Regulator clock with optional spread ----
    logic [7:0] lfsr_q; // Pseudo-random source
    logic [3:0] divCnt_q; // Cycle counter
    logic [3:0] period_q; // Current clock period
    wire [3:0] periodPick =
        !ctrl_q.regulatorSpreadEnable ? REG_CLK_DIV :
        (lfsr_q[1:0] == 2'h0) ? REG_CLK_DIV - SPREAD_STEP :
        (lfsr_q[1:0] == 2'h3) ? REG_CLK_DIV + SPREAD_STEP : REG_CLK_DIV;
    wire tick = (divCnt_q == period_q - 4'h1);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            lfsr_q <= LFSR_SEED;
            divCnt_q <= 4'h0;
            period_q <= REG_CLK_DIV;
        end else begin
            lfsr_q <= {lfsr_q[6:0],
                       lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
            if (tick) begin
                divCnt_q <= 4'h0;
                period_q <= periodPick;
            end else begin
                divCnt_q <= divCnt_q + 4'h1;
            end
        end
    end
    assign regClkTick = tick;

    // Switch cut-offs held to the end of the cycle
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            hsSwitchOff <= 1'b0;
            lsSwitchOff <= 1'b0;
        end else begin
            hsSwitchOff <= pinS.hsOverLimit || (hsSwitchOff && !tick);
            lsSwitchOff <= pinS.lsOverLimit || (lsSwitchOff && !tick);
        end
    end

    // ---- Regulator sequencing with autoretry ----
    sd_reg_state_t state_q; // Sequencer state
    logic retrying_q; // In hiccup operation
    logic [TIMER_W-1:0] timer_q; // Off and soft-start timer
    logic shdn_q; // Thermal shutdown
    wire timerDone = (timer_q == '0);
    wire overload = pinS.hsOverLimit || pinS.lsOverLimit;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state_q <= REG_SOFTSTART;
            retrying_q <= 1'b0;
            timer_q <= TIMER_W'(SOFTSTART_CYCLES);
        end else begin
            case (state_q)
                REG_SOFTSTART: begin
                    if (!timerDone) begin
                        timer_q <= timer_q - TIMER_W'(1);
                    end
                    if (pinS.outAbove95) begin
                        state_q <= REG_NORMAL;
                        retrying_q <= 1'b0;
                    end else if (timerDone && retrying_q) begin
                        // Fault persists: another off period
                        state_q <= REG_RETRY_OFF;
                        timer_q <= TIMER_W'(AUTORETRY_CYCLES);
                    end
                end
                REG_NORMAL: begin
                    if (pinS.outBelow70) begin
                        state_q <= REG_RETRY_OFF;
                        retrying_q <= 1'b1;
                        timer_q <= TIMER_W'(AUTORETRY_CYCLES);
                    end
                end
                REG_RETRY_OFF: begin
                    if (timerDone) begin
                        state_q <= REG_SOFTSTART;
                        timer_q <= TIMER_W'(SOFTSTART_CYCLES);
                    end else begin
                        timer_q <= timer_q - TIMER_W'(1);
                    end
                end
                default: begin
                    state_q <= REG_SOFTSTART;
                end
            endcase
        end
    end

    // Regulator flags and enables
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            regulatorGoodFlag <= 1'b0;
            regulatorFaultFlag <= 1'b0;
        end else begin
            regulatorGoodFlag <= (state_q == REG_NORMAL)
                && pinS.outAbove95 && !retrying_q;
            regulatorFaultFlag <= overload || retrying_q
                || ((state_q == REG_NORMAL) && pinS.outBelow70);
        end
    end
    assign powerGoodOut = regulatorGoodFlag;
    assign regEnable = (state_q != REG_RETRY_OFF) && !shdn_q;

    // ---- Thermal shutdown, always active ----
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            shdn_q <= 1'b0;
        end else if (tempS >= SHDN_ENTER_CODE) begin
            shdn_q <= 1'b1;
        end else if (tempS < SHDN_EXIT_CODE) begin
            shdn_q <= 1'b0;
        end
    end
    assign thermalShutdown = shdn_q;
    assign ldoEnable = !shdn_q;
    assign lineDriverEnable = !shdn_q && !setupLost_q;

    // ---- Temperature warning ----
    wire manualMode = ctrl_q.tempMonitorSelect[1];
    wire progMode = (ctrl_q.tempMonitorSelect == MON_PROG);
    wire [5:0] warnThr =
        progMode ? ctrl_q.tempWarnThreshold : WARN_DEFAULT_CODE;
    wire overWarn = !manualMode && (tempS > warnThr);
    wire belowHyst = progMode ? !(tempS > warnThr)
        : ({1'b0, tempS} + {1'b0, WARN_HYST_CODE} <= {1'b0, warnThr});

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tempWarnStatus <= 1'b0;
            tempWarnIrqFlag <= 1'b0;
        end else begin
            // Status follows level; hysteresis only with the default threshold
            if (manualMode) begin
                tempWarnStatus <= 1'b0;
            end else if (overWarn) begin
                tempWarnStatus <= 1'b1;
            end else if (belowHyst) begin
                tempWarnStatus <= 1'b0;
            end
            // Latched flag: set wins over a read
            if (overWarn) begin
                tempWarnIrqFlag <= 1'b1;
            end else if (intReadEv) begin
                tempWarnIrqFlag <= 1'b0;
            end
        end
    end
    assign irq = (tempWarnIrqFlag && !ctrl_q.tempWarnIrqMask)
        || setupLost_q;

    // ---- Manual conversion ----
    logic [12:0] convCnt_q; // Conversion time counter
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            convGo <= 1'b0;
            convDone <= 1'b0;
            tempResult <= 6'h00;
            convCnt_q <= 13'h0000;
        end else if (convGo) begin
            if (convCnt_q == 13'h0000) begin
                convGo <= 1'b0;
                convDone <= 1'b1;
                tempResult <= tempS;
            end else begin
                convCnt_q <= convCnt_q - 13'h0001;
            end
        end else if (convGoWrite && manualMode) begin
            convGo <= 1'b1;
            convDone <= 1'b0;
            convCnt_q <= 13'(CONV_CYCLES - 1);
        end
    end

    // ---- Checks ----
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_hs_cutoff: assert property (pinS.hsOverLimit |=> hsSwitchOff)
        else $error("high side not cut");
    a_ls_float: assert property (
        pinS.lsOverLimit || (lsSwitchOff && !tick) |=> lsSwitchOff)
        else $error("low side not floated");
    a_retry_enter: assert property (
        state_q == REG_NORMAL && pinS.outBelow70
        |=> !regEnable ##1 regulatorFaultFlag)
        else $error("autoretry not entered");
    a_retry_exit: assert property (
        state_q == REG_SOFTSTART && pinS.outAbove95
        |=> state_q == REG_NORMAL && !retrying_q)
        else $error("hiccup not left at 95 percent");
    a_good_level: assert property (
        regulatorGoodFlag |-> $past(pinS.outAbove95))
        else $error("good flag without output level");
    a_fault_hiccup: assert property (
        state_q == REG_RETRY_OFF |=> regulatorFaultFlag)
        else $error("fault flag clear in hiccup");
    a_warn_raise: assert property (
        !manualMode && tempS > warnThr |=> tempWarnIrqFlag && tempWarnStatus)
        else $error("warning not raised");
    a_warn_manual: assert property (
        manualMode |=> !tempWarnStatus)
        else $error("warning active in manual mode");
    a_irq_mask: assert property (
        tempWarnIrqFlag && !ctrl_q.tempWarnIrqMask |-> irq)
        else $error("unmasked warning without interrupt");
    a_conv_end: assert property (
        convGo && convCnt_q == 13'h0000
        |=> !convGo && convDone && tempResult == $past(tempS))
        else $error("conversion end wrong");
    a_shdn_gate: assert property (
        shdn_q |-> !regEnable && !lineDriverEnable && !ldoEnable)
        else $error("outputs live in shutdown");
    a_upset_set: assert property (
        mismatch |=> upset_q && setupLost_q && irq && !lineDriverEnable)
        else $error("upset not flagged");
    a_ready_read: assert property (
        intReadEv && !upset_q && !mismatch |=> !setupLost_q)
        else $error("not-ready not cleared by read");
endmodule : sd_supervisor_diag

// ==== rtl/sd_pkg.sv ====
// Purpose: Shared constants and types of the supervisor diagnostics block
// Assumes: mclk at 10 MHz; die temperature arrives as a 6-bit code
// Notes:   Codes are 3 C per count with zero at -15 C
package sd_pkg;
    // Clock rate and timing figures
    localparam int CLK_MHZ = 10;
    localparam int AUTORETRY_OFF_US = 22000;
    localparam int AUTORETRY_OFF_CYC = AUTORETRY_OFF_US * CLK_MHZ;
    localparam int SOFTSTART_US = 3300;
    localparam int SOFTSTART_CYC = SOFTSTART_US * CLK_MHZ;
    localparam int CONV_TIME_US = 450;
    localparam int CONV_CYC = CONV_TIME_US * CLK_MHZ;
    localparam int TIMER_W = 18;
    // Regulator clock divider and spread
    localparam logic [3:0] REG_CLK_DIV = 4'h000a;
    localparam int SPREAD_PCT = 10;
    localparam logic [3:0] SPREAD_STEP = 4'(10 * SPREAD_PCT / 100);
    localparam logic [7:0] LFSR_SEED = 8'h00a5;
    // Temperature code scale
    localparam int TEMP_OFFSET_C = 15;
    localparam int TEMP_STEP_C = 3;
    localparam int WARN_DEFAULT_C = 150;
    localparam logic [5:0] WARN_DEFAULT_CODE =
        6'((WARN_DEFAULT_C + TEMP_OFFSET_C) / TEMP_STEP_C);
    localparam int WARN_HYST_C = 15;
    localparam logic [5:0] WARN_HYST_CODE = 6'(WARN_HYST_C / TEMP_STEP_C);
    localparam int SHDN_ENTER_C = 170;
    localparam logic [5:0] SHDN_ENTER_CODE =
        6'((SHDN_ENTER_C + TEMP_OFFSET_C) / TEMP_STEP_C + 1);
    localparam int SHDN_HYST_C = 20;
    localparam logic [5:0] SHDN_EXIT_CODE =
        6'((SHDN_ENTER_C - SHDN_HYST_C + TEMP_OFFSET_C) / TEMP_STEP_C);
    // Temperature monitor select values
    localparam logic [1:0] MON_DEFAULT = 2'h0;
    localparam logic [1:0] MON_PROG = 2'h1;
    // Serial link framing and readable offsets
    localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
    localparam logic [4:0] SPI_CMD_BITS = 5'h08;
    localparam logic [6:0] ADDR_INTERRUPT = 7'h00;
    localparam logic [6:0] ADDR_STATUS = 7'h02;
    localparam logic [6:0] ADDR_SUPPLY_STATUS = 7'h03;
    localparam logic [6:0] ADDR_TEMP_RESULT = 7'h0f;

    // Control register image
    typedef struct packed {
        logic regulatorSpreadEnable;
        logic tempWarnIrqMask;
        logic [1:0] tempMonitorSelect;
        logic [5:0] tempWarnThreshold;
    } sd_ctrl_t;
    localparam int CTRL_W = 10;
    localparam sd_ctrl_t CTRL_RESET = 10'h000;

    // Comparator pins from the analog side
    typedef struct packed {
        logic hsOverLimit;
        logic lsOverLimit;
        logic outBelow70;
        logic outAbove95;
    } sd_pins_t;
    localparam int PINS_W = 4;

    // Status carried to the serial link
    typedef struct packed {
        logic setupLostFlag;
        logic tempWarnIrqFlag;
        logic tempWarnStatus;
        logic regUpsetFlag;
        logic regulatorFaultFlag;
        logic regulatorGoodFlag;
        logic convDone;
        logic [5:0] tempResult;
    } sd_stat_t;
    localparam int STAT_W = 13;

    // Regulator sequencing states
    typedef enum logic [1:0] {
        REG_SOFTSTART,
        REG_NORMAL,
        REG_RETRY_OFF
    } sd_reg_state_t;
endpackage : sd_pkg

// ==== rtl/sd_sync2.sv ====
// Purpose: Two flip-flop synchroniser for a vector of levels
// Assumes: Each bit is a slow level; bits are not coherent as a word
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module sd_sync2 #(
    parameter int W = 1
) (
    clk,
    din,
    dout
);
    input wire logic clk;
    input wire logic [W-1:0] din;
    output logic [W-1:0] dout;

    logic [W-1:0] meta_q; // First stage, metastable

    // Two-stage capture
    always_ff @(posedge clk) begin
        meta_q <= din;
        dout <= meta_q;
    end
endmodule : sd_sync2

// ==== rtl/sd_spi_link.sv ====
// Purpose: Mode-0 serial read port on the master's clock
// Assumes: 16-bit frame, R bit then 7-bit offset, then 8 data bits
// Notes:   Counters reset while chip select is high
`timescale 1ns/1ps
module sd_spi_link
    import sd_pkg::*;
(
    input wire logic sclk,
    input wire logic csN,
    input wire logic mosi,
    output logic miso,
    input wire sd_stat_t statIn,
    output logic intReadDone
);
    sd_stat_t statS; // Status in link domain
    logic [4:0] bitCnt_q; // Rising edges in frame
    logic [7:0] cmdShift_q; // Command shift register
    logic [7:0] cmd_q; // Captured command byte
    logic [7:0] txShift_q; // Outgoing byte
    wire [6:0] addrNow = cmdShift_q[6:0];
    wire isReadNow = cmdShift_q[7];
    wire [7:0] byteInt = {statS.setupLostFlag, 6'h00, statS.tempWarnIrqFlag};
    wire [7:0] byteStat = {7'h00, statS.tempWarnStatus};
    wire [7:0] byteSup = {statS.regUpsetFlag, 5'h00,
                          statS.regulatorFaultFlag, statS.regulatorGoodFlag};
    wire [7:0] byteRes = {statS.convDone, 1'b0, statS.tempResult};
    wire [7:0] txByte =
        !isReadNow ? 8'h00 :
        (addrNow == ADDR_INTERRUPT) ? byteInt :
        (addrNow == ADDR_STATUS) ? byteStat :
        (addrNow == ADDR_SUPPLY_STATUS) ? byteSup :
        (addrNow == ADDR_TEMP_RESULT) ? byteRes : 8'h00;
    wire lastEdge = (bitCnt_q == SPI_FRAME_BITS - 5'h01);
    wire intHit = cmd_q[7] && (cmd_q[6:0] == ADDR_INTERRUPT);

    // Status levels enter the link domain
    sd_sync2 #(.W(STAT_W)) uStatSync (
        .clk(sclk),
        .din(statIn),
        .dout(statS)
    );

    // Sample on rising edge, mode 0
    always_ff @(posedge sclk or posedge csN) begin
        if (csN) begin
            bitCnt_q <= 5'h00;
            cmdShift_q <= 8'h00;
            cmd_q <= 8'h00;
            intReadDone <= 1'b0;
        end else begin
            if (bitCnt_q < SPI_FRAME_BITS) begin
                bitCnt_q <= bitCnt_q + 5'h01;
            end
            if (bitCnt_q < SPI_CMD_BITS) begin
                cmdShift_q <= {cmdShift_q[6:0], mosi};
            end
            if (bitCnt_q == SPI_CMD_BITS) begin
                cmd_q <= cmdShift_q;
            end
            // Frame completed as an interrupt-register read
            if (lastEdge && intHit) begin
                intReadDone <= 1'b1;
            end
        end
    end

    // Drive on falling edge, data byte after the command
    always_ff @(negedge sclk or posedge csN) begin
        if (csN) begin
            txShift_q <= 8'h00;
        end else if (bitCnt_q == SPI_CMD_BITS) begin
            txShift_q <= txByte;
        end else begin
            txShift_q <= {txShift_q[6:0], 1'b0};
        end
    end

    assign miso = txShift_q[7];
endmodule : sd_spi_link

// ==== sim/sd_spi_master.sv ====
// Purpose: Mode-0 serial master model, reads only
// Assumes: Link clock 125 ns, low when idle
// Notes: Clock runs only inside frames
`timescale 1ns/1ps
module sd_spi_master (
    sclk,
    csN,
    mosi,
    miso
);
    output logic sclk;
    output logic csN;
    output logic mosi;
    input wire logic miso;
    // Idle link
    initial begin
        sclk = 1'b0;
        csN = 1'b1;
        mosi = 1'b1;
    end
    // One 16-bit read frame, first bit out first
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        logic [15:0] f;
        f = {1'b1, a, 8'h00};
        csN = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = f[i];
            #62.5 sclk = 1'b1;
            if (i < 8) d[i] = miso;
            #62.5 sclk = 1'b0;
        end
        #62.5 csN = 1'b1;
        mosi = ~mosi;
    endtask : rd
endmodule : sd_spi_master

// ==== sim/supervisor_diagnostics_tb.sv ====
// Purpose: Self-checking bench of the supervisor diagnostics block
// Assumes: Inputs change on falling mclk; short timing parameters
// Notes: Warning modes as table rows; hand tests follow
`timescale 1ns/1ps
module supervisor_diagnostics_tb;
    import sd_pkg::*;
    localparam int ARC = 40; // Short retry off time
    localparam int CVC = 20; // Short conversion time
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic cfgWrite = 1'b0;
    logic goW = 1'b0;
    sd_ctrl_t cfg = CTRL_RESET;
    logic [CTRL_W-1:0] flip = '0;
    sd_pins_t pins = '0;
    logic [5:0] temp = 6'h00;
    sd_ctrl_t ctrl;
    logic sclk, csN, mosi, miso, tick, hsOff, lsOff, regEn, good, fault;
    logic pg, warn, wIrq, irq, go, done, tsd, upset, lost, ldEn, ldoEn;
    logic [5:0] res;
    logic [7:0] rb;
    int fail_count = 0;
    int samples_checked = 0;
    int ticks = 0;
    int gap = 0; // Cycles since the last regulator tick
    int bad = 0; // Periods outside the spread band
    int varied = 0; // Periods off the nominal length
    // Row: control image, temperature, warning status, irq
    typedef struct packed {
        sd_ctrl_t c;
        logic [5:0] t;
        logic w;
        logic i;
    } sd_row_t;
    sd_row_t rows [7] = '{{10'h000, 6'h32, 2'b00}, {10'h000, 6'h38, 2'b11},
        {10'h000, 6'h33, 2'b11},
        {10'h100, 6'h38, 2'b10}, {10'h16f, 6'h2f, 2'b00},
        {10'h145, 6'h06, 2'b10}, {10'h185, 6'h06, 2'b00}};
    sd_spi_master spiM (.sclk(sclk), .csN(csN), .mosi(mosi), .miso(miso));
    sd_supervisor_diag #(.AUTORETRY_CYCLES(ARC), .SOFTSTART_CYCLES(30),
        .CONV_CYCLES(CVC)) DUT (.mclk(mclk), .rst_n(rst_n), .sclk(sclk),
        .csN(csN), .mosi(mosi), .miso(miso), .cfgWrite(cfgWrite),
        .cfgData(cfg), .convGoWrite(goW), .upsetFlip(flip),
        .analogPins(pins), .dieTempCode(temp), .ctrlOut(ctrl),
        .regClkTick(tick), .hsSwitchOff(hsOff), .lsSwitchOff(lsOff),
        .regEnable(regEn), .regulatorGoodFlag(good),
        .regulatorFaultFlag(fault), .powerGoodOut(pg),
        .tempWarnStatus(warn), .tempWarnIrqFlag(wIrq), .irq(irq),
        .convGo(go), .convDone(done), .tempResult(res),
        .thermalShutdown(tsd), .regUpsetFlag(upset), .setupLostFlag(lost),
        .lineDriverEnable(ldEn), .ldoEnable(ldoEn));
    // 10 MHz clock
    always #50 mclk = ~mclk;
    task automatic chk(input string n, input logic [9:0] s, e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask : cyc
    task automatic wr(input sd_ctrl_t c);
        cfg = c;
        cfgWrite = 1'b1;
        cyc(1);
        cfgWrite = 1'b0;
        cyc(3);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        spiM.rd(a, rb);
        chk("link", rb, e);
        cyc(8);
    endtask : rd
    task automatic results;
        $display("Checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : results
    // Main sequence
    initial begin
        cyc(20);
        chk("ctrl", ctrl, 0);
        chk("lost", lost, 1);
        rst_n = 1'b1;
        repeat (100) begin
            cyc(1);
            ticks += tick;
        end
        chk("ticks", 10'(ticks), 10);
        // Spread on: every period within 9 to 11 cycles, not all 10
        wr(10'h200);
        while (!tick) begin
            cyc(1);
        end
        repeat (200) begin
            cyc(1);
            gap++;
            if (tick) begin
                bad += (gap < 9 || gap > 11);
                varied += (gap != 10);
                gap = 0;
            end
        end
        chk("spread", {bad == 0, varied > 0}, 3);
        wr(10'h000);
        rd(7'h00, 8'h80);
        chk("irq", irq, 0);
        foreach (rows[k]) begin
            temp = rows[k].t;
            wr(rows[k].c);
            cyc(6);
            chk("warn", warn, rows[k].w);
            chk("irq", irq, rows[k].i);
        end
        wr(10'h000);
        chk("irq", irq, 1);
        rd(7'h00, 8'h01);
        chk("wIrq", {wIrq, irq}, 0);
        goW = 1'b1;
        cyc(1);
        goW = 1'b0;
        chk("go", go, 0);
        temp = 6'h2f;
        wr(10'h180);
        goW = 1'b1;
        cyc(1);
        goW = 1'b0;
        cyc(CVC - 2);
        chk("go", {go, done}, 2);
        cyc(3);
        chk("conv", {go, done, res}, 10'h06f);
        rd(7'h0f, 8'haf);
        wr(10'h000);
        pins.outAbove95 = 1'b1;
        cyc(6);
        chk("good", {good, pg, fault}, 6);
        pins = 4'h2;
        cyc(6);
        chk("hic", {regEn, fault, good, pg}, 4);
        cyc(ARC);
        chk("retry", regEn, 1);
        cyc(30);
        chk("again", {regEn, fault}, 1);
        cyc(ARC + 3);
        chk("retry", regEn, 1);
        pins = 4'h1;
        cyc(6);
        chk("norm", {regEn, fault, good}, 5);
        rd(7'h03, 8'h01);
        pins = 4'hd;
        cyc(4);
        chk("sw", {hsOff, lsOff}, 3);
        pins = 4'h1;
        cyc(15);
        chk("sw", {hsOff, lsOff}, 0);
        temp = 6'h3e;
        cyc(4);
        chk("tsd", {tsd, ldoEn, ldEn, regEn}, 8);
        temp = 6'h37;
        cyc(4);
        chk("tsd", tsd, 1);
        temp = 6'h28;
        cyc(4);
        chk("tsd", {tsd, ldoEn, ldEn}, 3);
        flip[9] = 1'b1;
        cyc(4);
        flip[9] = 1'b0;
        cyc(3);
        chk("up", {upset, lost, irq, ldEn, ctrl[9]}, 29);
        wr(10'h000);
        chk("up", {upset, lost}, 1);
        rd(7'h00, 8'h81);
        chk("lost", {lost, irq, ldEn}, 1);
        // Reset in mid-run
        rst_n = 1'b0;
        cyc(3);
        chk("rst", {lost, irq, ldEn, regEn, good, done}, 6'h34);
        rst_n = 1'b1;
        cyc(2);
        chk("rst", {lost, irq, ctrl[9]}, 6);
        results();
    end
    // Watchdog
    initial begin
        #300000;
        fail_count++;
        results();
    end
endmodule : supervisor_diagnostics_tb
